// File: sss_pkg.sv
`default_nettype none

package sss_pkg;

  // loop timing
  localparam int unsigned CLK_KHZ       = 20000;
  localparam int unsigned LOOP_TIME_MS  = 10;
  localparam int unsigned LOOP_CYCLES   = LOOP_TIME_MS * CLK_KHZ;

  // speed figures in km/h
  localparam logic [7:0] SHUTOFF_DFLT_KMPH = 8'h19;
  localparam logic [7:0] GAIN_BAND_KMPH    = 8'h0a;

  // spool and wheel angle limits
  localparam logic [11:0]        SPOOL_TOL = 12'h040;
  localparam logic signed [11:0] WA_LIMIT  = 12'sh3cf;
  localparam logic signed [11:0] SP_ZERO   = 12'sh000;

  // programs and gains
  localparam logic [2:0] NUM_PROG  = 3'h5;
  localparam logic [2:0] PROG_RST  = 3'h0;
  localparam logic [7:0] GAIN_RST  = 8'h10;
  localparam int unsigned GAIN_SHIFT = 4;
  localparam int unsigned GAIN_WORDS = 16;

  // cause bit positions
  localparam int unsigned CAUSE_FAULT = 0;
  localparam int unsigned CAUSE_SPEED = 1;
  localparam int unsigned CAUSE_XCHK  = 2;
  localparam int unsigned CAUSE_SPOOL = 3;

  typedef enum logic [1:0] {
    SSS_MODE_WHEEL = 2'h0,
    SSS_MODE_AUTO  = 2'h1,
    SSS_MODE_AUX   = 2'h3,
    SSS_MODE_ROAD  = 2'h2
  } sss_mode_e;

  typedef enum logic [1:0] {
    SSS_ST_INIT = 2'h0,
    SSS_ST_RUN  = 2'h1,
    SSS_ST_SAFE = 2'h3
  } sss_sup_e;

  typedef struct packed {
    logic [7:0]         speed;
    sss_mode_e          mode;
    logic signed [11:0] wheel_angle;
    logic signed [11:0] setpoint;
  } sss_xchk_s;

  typedef struct packed {
    logic       valid;
    logic       aux;
    logic [2:0] prog;
  } sss_preq_s;

  typedef struct packed {
    logic [7:0]         speed;
    logic [7:0]         shutoff_thr;
    logic               shutoff_cfg;
    logic [7:0]         lock_thr;
    sss_mode_e          mode;
    logic               normal_op;
    logic               single_ch;
    logic [3:0]         faults;
    logic signed [11:0] wheel_angle;
    logic signed [11:0] wheel_rate;
    logic signed [11:0] guid_cmd;
    logic signed [11:0] spool_main;
    logic signed [11:0] spool_safe;
    sss_xchk_s          safe_ch;
    sss_preq_s          preq;
  } sss_pins_s;

  typedef struct packed {
    logic       en;
    logic [3:0] addr;
    logic [7:0] data;
  } sss_gwr_s;

  typedef struct packed {
    logic       safe;
    logic [3:0] cause;
    logic       lock;
    logic       req_exec;
    logic       req_ign;
    logic [2:0] wheel_prog;
    logic [2:0] aux_prog;
    sss_sup_e   state;
  } sss_status_s;

  function automatic logic [11:0] sss_absdiff(input logic signed [11:0] a,
                                              input logic signed [11:0] b);
    logic signed [12:0] d;
    d = 13'(a) - 13'(b);
    if (d < 0) d = -d;
    return 12'(d);
  endfunction : sss_absdiff

  function automatic logic signed [11:0] sss_sat12(input logic signed [20:0] v);
    logic signed [11:0] r;
    r = 12'(v);
    if (v > 21'sh0007ff) r = 12'sh7ff;
    if (v < -21'sh000800) r = 12'sh800;
    return r;
  endfunction : sss_sat12

endpackage : sss_pkg

`default_nettype wire

// File: sss_gain_mem.sv
`timescale 1ns/10ps
`default_nettype none

module sss_gain_mem (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             resetn_i,
  // write port
  input  wire sss_pkg::sss_gwr_s wr_i,
  // read port
  input  wire logic [3:0]       rd_addr_i,
  output logic [7:0]            rd_data_o
);

  logic [7:0] mem_reg [sss_pkg::GAIN_WORDS];
  logic [7:0] rd_data_reg;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < sss_pkg::GAIN_WORDS; i++) begin
        mem_reg[i] <= sss_pkg::GAIN_RST;
      end
    end else if (wr_i.en) begin
      mem_reg[wr_i.addr] <= wr_i.data;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      rd_data_reg <= sss_pkg::GAIN_RST;
    end else begin
      rd_data_reg <= mem_reg[rd_addr_i];
    end
  end

  assign rd_data_o = rd_data_reg;

endmodule : sss_gain_mem

`default_nettype wire

// File: sss_top.sv
`timescale 1ns/10ps
`default_nettype none

module sss_top #(
  parameter int unsigned LOOP_CYCLES = sss_pkg::LOOP_CYCLES
) (
  // clock and reset
  input  wire logic                clk_i,
  input  wire logic                resetn_i,
  // sensor, config and request pins
  input  wire sss_pkg::sss_pins_s  pins_i,
  // gain table write from local config logic
  input  wire sss_pkg::sss_gwr_s   gain_wr_i,
  // valve drivers
  output logic                     valve_en_main_o,
  output logic                     valve_en_safe_o,
  output logic signed [11:0]       spool_setpoint_o,
  // operation status
  output sss_pkg::sss_status_s     status_o
);

  localparam int unsigned CW = $clog2(LOOP_CYCLES + 1);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser

  sss_pkg::sss_pins_s pins_meta_reg;
  sss_pkg::sss_pins_s pins_reg;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      pins_meta_reg <= '0;
      pins_reg      <= '0;
    end else begin
      pins_meta_reg <= pins_i;
      pins_reg      <= pins_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control loop tick

  logic [CW-1:0] cnt_reg;
  logic          tick_reg;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
    end else if (cnt_reg == CW'(LOOP_CYCLES - 1)) begin
      cnt_reg  <= '0;
      tick_reg <= 1'b1;
    end else begin
      cnt_reg  <= cnt_reg + 1'b1;
      tick_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // demand sources

  sss_pkg::sss_sup_e  state_reg;
  sss_pkg::sss_sup_e  state_next;
  logic signed [11:0] setpoint_reg;
  logic [7:0]         shutoff_eff;
  logic               overspeed;
  logic               mismatch;
  logic               spool_err;
  logic               fault_any;
  logic               demand;

  assign shutoff_eff = pins_reg.shutoff_cfg ? pins_reg.shutoff_thr
                                            : sss_pkg::SHUTOFF_DFLT_KMPH;
  assign overspeed = (pins_reg.mode != sss_pkg::SSS_MODE_ROAD) &&
                     (pins_reg.speed > shutoff_eff);
  assign mismatch = pins_reg.normal_op &&
                    ((pins_reg.safe_ch.speed != pins_reg.speed) ||
                     (pins_reg.safe_ch.mode != pins_reg.mode) ||
                     (pins_reg.safe_ch.wheel_angle != pins_reg.wheel_angle) ||
                     (pins_reg.safe_ch.setpoint != setpoint_reg));
  assign spool_err = (state_reg == sss_pkg::SSS_ST_RUN) &&
                     ((sss_pkg::sss_absdiff(pins_reg.spool_main, setpoint_reg)
                       > sss_pkg::SPOOL_TOL) ||
                      (sss_pkg::sss_absdiff(pins_reg.spool_safe, setpoint_reg)
                       > sss_pkg::SPOOL_TOL));
  assign fault_any = |pins_reg.faults;
  assign demand    = fault_any || (tick_reg && (overspeed || mismatch || spool_err));

  ////////////////////////////////////////////////////////////////////////////
  // supervisor state

  always_comb begin
    case (state_reg)
      sss_pkg::SSS_ST_INIT: begin
        if (demand) state_next = sss_pkg::SSS_ST_SAFE;
        else if (tick_reg) state_next = sss_pkg::SSS_ST_RUN;
        else state_next = sss_pkg::SSS_ST_INIT;
      end
      sss_pkg::SSS_ST_RUN: begin
        state_next = demand ? sss_pkg::SSS_ST_SAFE : sss_pkg::SSS_ST_RUN;
      end
      default: begin
        state_next = sss_pkg::SSS_ST_SAFE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      state_reg <= sss_pkg::SSS_ST_INIT;
    end else begin
      state_reg <= state_next;
    end
  end

  logic [3:0] cause_reg;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      cause_reg <= '0;
    end else if (state_reg != sss_pkg::SSS_ST_SAFE) begin
      cause_reg[sss_pkg::CAUSE_FAULT] <= fault_any;
      cause_reg[sss_pkg::CAUSE_SPEED] <= tick_reg && overspeed;
      cause_reg[sss_pkg::CAUSE_XCHK]  <= tick_reg && mismatch;
      cause_reg[sss_pkg::CAUSE_SPOOL] <= tick_reg && spool_err;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // valve outputs

  logic valve_en_main_reg;
  logic valve_en_safe_reg;

  // both drop, single keeps main only
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      valve_en_main_reg <= 1'b0;
      valve_en_safe_reg <= 1'b0;
    end else begin
      valve_en_main_reg <= (state_next == sss_pkg::SSS_ST_RUN);
      valve_en_safe_reg <= (state_next == sss_pkg::SSS_ST_RUN) && !pins_reg.single_ch;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // program lock-out

  logic       lock_reg;
  logic       preq_prev_reg;
  logic       req_fire;
  logic       req_exec_reg;
  logic       req_ign_reg;
  logic [2:0] wheel_prog_reg;
  logic [2:0] aux_prog_reg;

  assign req_fire = pins_reg.preq.valid && !preq_prev_reg;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      lock_reg      <= 1'b0;
      preq_prev_reg <= 1'b0;
    end else begin
      preq_prev_reg <= pins_reg.preq.valid;
      if (tick_reg) lock_reg <= pins_reg.speed > pins_reg.lock_thr;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      wheel_prog_reg <= sss_pkg::PROG_RST;
      aux_prog_reg   <= sss_pkg::PROG_RST;
      req_exec_reg   <= 1'b0;
      req_ign_reg    <= 1'b0;
    end else if (req_fire) begin
      if (lock_reg || (pins_reg.preq.prog >= sss_pkg::NUM_PROG)) begin
        req_exec_reg <= 1'b0;
        req_ign_reg  <= 1'b1;
      end else begin
        req_exec_reg <= 1'b1;
        req_ign_reg  <= 1'b0;
        if (pins_reg.preq.aux) aux_prog_reg <= pins_reg.preq.prog;
        else wheel_prog_reg <= pins_reg.preq.prog;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // set-point computation

  logic [7:0]         gain;
  logic [2:0]         gain_prog;
  logic               speed_band;
  logic signed [20:0] prod;
  logic signed [11:0] cmd;
  logic signed [11:0] cmd_lim;

  assign gain_prog  = (pins_reg.mode == sss_pkg::SSS_MODE_AUX) ? aux_prog_reg
                                                               : wheel_prog_reg;
  assign speed_band = pins_reg.speed > sss_pkg::GAIN_BAND_KMPH;

  sss_gain_mem u_gain_mem (
    .clk_i     (clk_i),
    .resetn_i  (resetn_i),
    .wr_i      (gain_wr_i),
    .rd_addr_i ({gain_prog, speed_band}),
    .rd_data_o (gain)
  );

  always_comb begin
    prod = 21'(pins_reg.wheel_rate) * 21'($signed({1'b0, gain}));
    case (pins_reg.mode)
      sss_pkg::SSS_MODE_WHEEL: cmd = sss_pkg::sss_sat12(prod >>> sss_pkg::GAIN_SHIFT);
      sss_pkg::SSS_MODE_AUTO:  cmd = pins_reg.guid_cmd;
      sss_pkg::SSS_MODE_AUX:   cmd = sss_pkg::sss_sat12(prod >>> sss_pkg::GAIN_SHIFT);
      default:                 cmd = sss_pkg::SP_ZERO;
    endcase
    // no flow further into an end stop
    cmd_lim = cmd;
    if ((pins_reg.wheel_angle > sss_pkg::WA_LIMIT && cmd > 0) ||
        (pins_reg.wheel_angle < -sss_pkg::WA_LIMIT && cmd < 0)) begin
      cmd_lim = sss_pkg::SP_ZERO;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      setpoint_reg <= sss_pkg::SP_ZERO;
    end else if (state_next != sss_pkg::SSS_ST_RUN) begin
      setpoint_reg <= sss_pkg::SP_ZERO;
    end else if (tick_reg) begin
      setpoint_reg <= pins_reg.normal_op ? cmd_lim : sss_pkg::SP_ZERO;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign valve_en_main_o  = valve_en_main_reg;
  assign valve_en_safe_o  = valve_en_safe_reg;
  assign spool_setpoint_o = setpoint_reg;
  // safe is the one state with bit 1 set, so the flag is a flop bit
  assign status_o = '{safe: state_reg[1], cause: cause_reg,
                      lock: lock_reg, req_exec: req_exec_reg, req_ign: req_ign_reg,
                      wheel_prog: wheel_prog_reg, aux_prog: aux_prog_reg,
                      state: state_reg};

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_overspeed;
    tick_reg && overspeed;
  endsequence

  sequence s_req_locked;
    req_fire && lock_reg;
  endsequence

  a_safe_latched:
    assert property (state_reg == sss_pkg::SSS_ST_SAFE |=> state_reg == sss_pkg::SSS_ST_SAFE)
      else $error("safe state was left");
  a_valves_off:
    assert property (state_reg == sss_pkg::SSS_ST_SAFE |-> !valve_en_main_o && !valve_en_safe_o
                     && spool_setpoint_o == sss_pkg::SP_ZERO)
      else $error("valve energized in safe state");
  a_both_drop:
    assert property ($fell(valve_en_main_o) |-> !valve_en_safe_o)
      else $error("channels did not drop together");
  a_fault_demand:
    assert property (fault_any |=> state_reg == sss_pkg::SSS_ST_SAFE)
      else $error("fault did not force safe state");
  a_speed_shutoff:
    assert property (s_overspeed |=> state_reg == sss_pkg::SSS_ST_SAFE ##1 !valve_en_main_o)
      else $error("overspeed did not shut off");
  a_road_exempt:
    assert property (tick_reg && pins_reg.mode == sss_pkg::SSS_MODE_ROAD && !fault_any
                     && !mismatch && !spool_err |-> !demand)
      else $error("speed check active on road");
  a_default_thr:
    assert property (tick_reg && !pins_reg.shutoff_cfg && pins_reg.mode != sss_pkg::SSS_MODE_ROAD
                     && pins_reg.speed > sss_pkg::SHUTOFF_DFLT_KMPH |-> demand)
      else $error("default threshold wrong");
  a_xchk_demand:
    assert property (tick_reg && mismatch |=> state_reg == sss_pkg::SSS_ST_SAFE)
      else $error("channel mismatch ignored");
  a_loop_update:
    assert property (!$stable(setpoint_reg) && $past(state_next) == sss_pkg::SSS_ST_RUN
                     |-> $past(tick_reg))
      else $error("set-point changed off the loop tick");
  a_normal_only:
    assert property (tick_reg && !pins_reg.normal_op |=> setpoint_reg == sss_pkg::SP_ZERO)
      else $error("flow command outside normal operation");
  a_prog_lock:
    assert property (s_req_locked |=> $stable(wheel_prog_reg) && $stable(aux_prog_reg)
                     && req_ign_reg && !req_exec_reg)
      else $error("program change taken while locked");
  a_single_ch:
    assert property (pins_reg.single_ch |=> !valve_en_safe_o)
      else $error("second channel driven in single variant");

endmodule : sss_top

`default_nettype wire

// File: sss_far_side.sv
`timescale 1ns/10ps
`default_nettype none

module sss_far_side (
  // clock
  input  wire logic               clk_i,
  // sensor values also seen by the main channel
  input  wire logic [7:0]         speed_i,
  input  wire sss_pkg::sss_mode_e mode_i,
  input  wire logic signed [11:0] wa_i,
  // valve drive from the block
  input  wire logic               valve_en_i,
  input  wire logic signed [11:0] setpoint_i,
  // pace and fault injection
  input  wire logic               slow_i,
  input  wire logic               xbad_i,
  input  wire logic signed [11:0] serr_i,
  // shut-off cause seen by the system
  input  wire logic               shut_cause_i,
  // spool readback and second channel report
  output logic signed [11:0]      spool_main_o,
  output logic signed [11:0]      spool_safe_o,
  output sss_pkg::sss_xchk_s      safe_ch_o,
  // operator alarm
  output logic                    alarm_o
);
  logic signed [11:0] lag_q [3] = '{default: 12'sh000};

  ////////////////////////////////////////
  // spool tracks set-point, springs to centre when de-energized
  always_ff @(posedge clk_i) begin
    lag_q[0] <= valve_en_i ? setpoint_i : 12'sh000;
    lag_q[1] <= lag_q[0];
    lag_q[2] <= lag_q[1];
  end
  assign spool_safe_o = slow_i ? lag_q[2] : lag_q[0];
  assign spool_main_o = spool_safe_o + serr_i;

  // operator alarm while shut off for speed
  assign alarm_o = !valve_en_i && shut_cause_i;

  assign safe_ch_o = '{speed: speed_i + {7'h00, xbad_i}, mode: mode_i,
                       wheel_angle: wa_i, setpoint: setpoint_i};
endmodule : sss_far_side

`default_nettype wire

// File: sss_top_test.sv
`timescale 1ns/10ps
`default_nettype none

module sss_top_test;
  localparam int unsigned LOOP = 20;
  typedef struct {int kind; logic [15:0] val;} sss_note_s;
  logic                 clk_i;
  logic                 resetn_i;
  sss_pkg::sss_pins_s   drv;
  sss_pkg::sss_pins_s   pins_w;
  sss_pkg::sss_gwr_s    gwr;
  logic                 vm;
  logic                 vs;
  logic signed [11:0]   sp;
  sss_pkg::sss_status_s st;
  logic                 slow;
  logic                 xbad;
  logic signed [11:0]   serr;
  logic signed [11:0]   spm;
  logic signed [11:0]   sps;
  sss_pkg::sss_xchk_s   sch;
  logic                 alm;
  sss_note_s            notes[$];
  sss_note_s            note;
  int                   n_errors = 0;
  int                   total_checks = 0;
  logic [2:0]           wp;
  logic [2:0]           ap;
  logic                 lk;
  logic signed [11:0]   g;
  logic signed [11:0]   r;

  sss_top #(.LOOP_CYCLES(LOOP)) uut (.clk_i(clk_i), .resetn_i(resetn_i), .pins_i(pins_w),
    .gain_wr_i(gwr), .valve_en_main_o(vm), .valve_en_safe_o(vs), .spool_setpoint_o(sp),
    .status_o(st));
  sss_far_side far (.clk_i(clk_i), .speed_i(drv.speed), .mode_i(drv.mode),
    .wa_i(drv.wheel_angle), .valve_en_i(vm), .setpoint_i(sp), .slow_i(slow), .xbad_i(xbad),
    .serr_i(serr), .spool_main_o(spm), .spool_safe_o(sps), .safe_ch_o(sch),
    .shut_cause_i(st.cause[sss_pkg::CAUSE_SPEED]), .alarm_o(alm));

  always_comb begin
    pins_w = drv;
    pins_w.spool_main = spm;
    pins_w.spool_safe = sps;
    pins_w.safe_ch = sch;
  end

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  ////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input int kind);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: kind %0d seen %h expected %h", $time, kind, seen, exp);
    end
  endtask : check

  function automatic logic [15:0] observe(input int kind);
    case (kind)
      0: return {4'h0, sp};
      1: return {13'h0000, alm, vm, vs};
      2: return {9'h000, st.safe, st.cause, st.state};
      default: return {7'h00, st.lock, st.req_exec, st.req_ign, st.wheel_prog, st.aux_prog};
    endcase
  endfunction : observe

  // scoreboard: outputs seen at the edge, before that edge's updates land
  always @(posedge clk_i) begin
    while (notes.size() > 0) begin
      note = notes.pop_front();
      check(observe(note.kind), note.val, note.kind);
    end
  end

  task automatic cycles(input int n);
    repeat (n) @(negedge clk_i);
  endtask : cycles

  task automatic expect_out(input int kind, input logic [15:0] val);
    notes.push_back('{kind, val});
  endtask : expect_out

  function automatic logic [15:0] run_st(input logic safe, input logic [3:0] cause);
    return {9'h000, safe, cause, safe ? sss_pkg::SSS_ST_SAFE : sss_pkg::SSS_ST_RUN};
  endfunction : run_st

  task automatic do_reset();
    drv = '0;
    drv.normal_op = 1'b1;
    drv.mode = sss_pkg::SSS_MODE_AUTO;
    drv.shutoff_thr = 8'h28;
    drv.speed = 8'h05;
    drv.lock_thr = 8'h0f;
    gwr = '0;
    slow = 1'b0;
    xbad = 1'b0;
    serr = 12'sh000;
    resetn_i = 1'b0;
    cycles(4);
    resetn_i = 1'b1;
  endtask : do_reset

  task automatic sp_case(input sss_pkg::sss_mode_e m, input logic signed [11:0] wa,
                         input logic signed [11:0] cmd, input logic signed [11:0] rate,
                         input logic signed [11:0] exp);
    drv.mode = m;
    drv.wheel_angle = wa;
    drv.guid_cmd = cmd;
    drv.wheel_rate = rate;
    slow = ~slow;
    cycles(2 * LOOP + 2);
    expect_out(0, {4'h0, exp});
  endtask : sp_case

  task automatic request(input logic aux, input logic [2:0] prog);
    logic ok;
    ok = !lk && prog < 3'h5;
    if (ok && aux) ap = prog;
    if (ok && !aux) wp = prog;
    drv.preq = '{1'b1, aux, prog};
    cycles(4);
    expect_out(3, {7'h00, lk, ok, !ok, wp, ap});
    drv.preq.valid = 1'b0;
    cycles(2);
  endtask : request

  task automatic trip_case(input sss_pkg::sss_mode_e m, input logic cfg, input logic [7:0] spd,
                           input logic xb, input logic nop, input logic signed [11:0] se,
                           input logic [3:0] cause);
    logic [15:0] e;
    do_reset();
    drv.mode = m;
    drv.shutoff_cfg = cfg;
    drv.speed = spd;
    drv.normal_op = nop;
    drv.guid_cmd = 12'sh190;
    xbad = xb;
    serr = se;
    slow = 1'b1;
    cycles(3 * LOOP);
    expect_out(2, run_st(cause != 4'h0, cause));
    expect_out(1, {13'h0000, cause[1], cause == 4'h0, cause == 4'h0});
    e = (cause == 4'h0 && nop && m == sss_pkg::SSS_MODE_AUTO) ? 16'h0190 : 16'h0000;
    expect_out(0, e);
  endtask : trip_case

  ////////////////////////////////////////
  initial begin
    #1_000_000;
    n_errors++;
    close_out();
  end

  initial begin
    void'($urandom(2806));
    do_reset();
    cycles(2 * LOOP);
    expect_out(1, 16'h0003);
    expect_out(3, 16'h0000);
    g = 12'($urandom_range(1800)) - 12'sh384;
    r = 12'($urandom_range(400)) - 12'sh0c8;
    sp_case(sss_pkg::SSS_MODE_AUTO, 12'sh000, g, r, g);
    sp_case(sss_pkg::SSS_MODE_WHEEL, 12'sh000, g, r, r);
    sp_case(sss_pkg::SSS_MODE_AUX, 12'sh000, g, r, r);
    sp_case(sss_pkg::SSS_MODE_ROAD, 12'sh000, g, r, 12'sh000);
    sp_case(sss_pkg::SSS_MODE_AUTO, 12'sh3e8, 12'sh1f4, r, 12'sh000);
    sp_case(sss_pkg::SSS_MODE_AUTO, 12'sh3e8, -12'sh1f4, r, -12'sh1f4);
    gwr = '{1'b1, 4'h0, 8'h20};
    cycles(1);
    gwr.en = 1'b0;
    sp_case(sss_pkg::SSS_MODE_WHEEL, 12'sh000, g, 12'sh12c, 12'sh258);
    sp_case(sss_pkg::SSS_MODE_WHEEL, 12'sh000, g, 12'sh5dc, 12'sh7ff);
    drv.speed = 8'h0c;
    sp_case(sss_pkg::SSS_MODE_WHEEL, 12'sh000, g, 12'sh12c, 12'sh12c);
    // set-point moves only once per loop
    drv.speed = 8'h05;
    drv.mode = sss_pkg::SSS_MODE_AUTO;
    drv.guid_cmd = 12'sh0c8;
    for (int i = 0; i < 3 * LOOP && sp !== 12'sh0c8; i++) cycles(1);
    drv.guid_cmd = -12'sh0c8;
    cycles(LOOP - 3);
    expect_out(0, 16'h00c8);
    cycles(5);
    expect_out(0, 16'h0f38);
    wp = 3'h0;
    ap = 3'h0;
    lk = 1'b0;
    request(1'b0, 3'($urandom_range(4)));
    request(1'b1, 3'($urandom_range(4)));
    request(1'b0, 3'h5);
    drv.speed = 8'h10;
    cycles(2 * LOOP);
    lk = 1'b1;
    request(1'b0, 3'h2);
    request(1'b1, 3'h3);
    for (int i = 0; i < 4; i++) begin
      do_reset();
      drv.single_ch = i[0];
      cycles(2 * LOOP);
      expect_out(1, {14'h0000, 1'b1, !i[0]});
      drv.faults = 4'(1 << i);
      cycles(2);
      expect_out(1, {14'h0000, 1'b1, !i[0]});
      cycles(1);
      expect_out(1, 16'h0000);
      expect_out(2, run_st(1'b1, 4'h1));
      drv.faults = 4'h0;
      cycles(2 * LOOP);
      expect_out(2, run_st(1'b1, 4'h1));
    end
    trip_case(sss_pkg::SSS_MODE_AUTO, 1'b0, 8'h19, 1'b0, 1'b1, 12'sh000, 4'h0);
    trip_case(sss_pkg::SSS_MODE_AUTO, 1'b0, 8'h1a, 1'b0, 1'b1, 12'sh000, 4'h2);
    trip_case(sss_pkg::SSS_MODE_WHEEL, 1'b1, 8'h28, 1'b0, 1'b1, 12'sh000, 4'h0);
    trip_case(sss_pkg::SSS_MODE_WHEEL, 1'b1, 8'h29, 1'b0, 1'b1, 12'sh000, 4'h2);
    trip_case(sss_pkg::SSS_MODE_AUX, 1'b1, 8'h29, 1'b0, 1'b1, 12'sh000, 4'h2);
    trip_case(sss_pkg::SSS_MODE_ROAD, 1'b0, 8'hc8, 1'b0, 1'b1, 12'sh000, 4'h0);
    trip_case(sss_pkg::SSS_MODE_AUTO, 1'b0, 8'h05, 1'b1, 1'b1, 12'sh000, 4'h4);
    trip_case(sss_pkg::SSS_MODE_AUTO, 1'b0, 8'h05, 1'b1, 1'b0, 12'sh000, 4'h0);
    trip_case(sss_pkg::SSS_MODE_AUTO, 1'b0, 8'h05, 1'b0, 1'b1, 12'sh064, 4'h8);
    cycles(2);
    close_out();
  end
endmodule : sss_top_test

`default_nettype wire
